// ---- shared/pbc_pkg.sv ----
// Constants for the two-port pin control block.
// Assumes a 32-bit APB slave with word-aligned registers.
package pbc_pkg;
	// ==========================================
	// Register byte offsets, narrow port block
	localparam logic [7:0] PBC_OFF_NDATA = 8'h00;
	localparam logic [7:0] PBC_OFF_NOE = 8'h04;
	localparam logic [7:0] PBC_OFF_NFS1 = 8'h08;
	localparam logic [7:0] PBC_OFF_NFS2 = 8'h0c;
	localparam logic [7:0] PBC_OFF_NFS3 = 8'h10;
	localparam logic [7:0] PBC_OFF_NFS4 = 8'h14;
	localparam logic [7:0] PBC_OFF_NOD = 8'h28;
	localparam logic [7:0] PBC_OFF_NPUP = 8'h2c;
	localparam logic [7:0] PBC_OFF_NIE = 8'h38;
	// Wide port registers, placed above the narrow block
	localparam logic [7:0] PBC_OFF_WFS3 = 8'h40;
	localparam logic [7:0] PBC_OFF_WOD = 8'h44;
	localparam logic [7:0] PBC_OFF_WPUP = 8'h48;
	localparam logic [7:0] PBC_OFF_WIE = 8'h4c;
	// ==========================================
	// Widths and reset values
	localparam int PBC_WIDE_W = 8;
	localparam int PBC_NARROW_W = 3;
	localparam logic [7:0] PBC_WIDE_RST = 8'h00;
	localparam logic [2:0] PBC_NARROW_RST = 3'h0;
	// Serial one pin positions in function select 1
	localparam int PBC_SER_TX_BIT = 0;
	localparam int PBC_SER_RX_BIT = 1;
	localparam int PBC_SER_CLK_BIT = 2;
	// Only function select 4 bit 2 exists
	localparam logic [2:0] PBC_NFS4_MASK = 3'h4;
endpackage

// ---- logic/pbc_pin_cell.sv ----
// One pin's output stage: source select, drive type, enables.
// Assumes the caller passes one-hot function selects.
`timescale 1ns/10ps
module pbc_pin_cell
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic port_oe,
	input wire logic port_data,
	input wire logic alt_sel,
	input wire logic alt_oe,
	input wire logic alt_data,
	input wire logic open_drain,
	input wire logic pullup_en,
	input wire logic input_en,
	// Pad side
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe_n,
	output logic pad_pullup,
	output logic pin_value
);
	logic drv_en;
	logic drv_val;

	always_comb
	begin
		drv_en = alt_sel ? alt_oe : port_oe;
		drv_val = alt_sel ? alt_data : port_data;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_out <= 1'b0;
			pad_oe_n <= 1'b1;
			pad_pullup <= 1'b0;
			pin_value <= 1'b0;
		end
		else
		begin
			// Open drain only pulls low; a high releases the pin
			pad_out <= open_drain ? 1'b0 : drv_val;
			pad_oe_n <= ~(drv_en & (~open_drain | ~drv_val));
			pad_pullup <= pullup_en;
			// Gated buffer reads zero so a floating pad cannot leak in
			pin_value <= input_en & pad_in;
		end
	end
endmodule

// ---- logic/pbc_top.sv ----
// Pin control for an 8-bit wide port and a 3-bit narrow port.
// Assumes an APB master and pads that resolve oe_n and pull-ups.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps

module pbc_top
	import pbc_pkg::*;
#(
	parameter int WIDE_W = pbc_pkg::PBC_WIDE_W,
	parameter int NARROW_W = pbc_pkg::PBC_NARROW_W
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Wide port: the rest of that port joins here
	input wire logic [WIDE_W-1:0] wide_port_oe,
	input wire logic [WIDE_W-1:0] wide_port_data,
	input wire logic [WIDE_W-1:0] ext_addr,
	input wire logic ext_addr_oe,
	input wire logic [WIDE_W-1:0] wide_pad_in,
	output logic [WIDE_W-1:0] wide_pad_out,
	output logic [WIDE_W-1:0] wide_pad_oe_n,
	output logic [WIDE_W-1:0] wide_pad_pullup,
	output logic [WIDE_W-1:0] wide_pin_value,
	output logic [WIDE_W-1:0] wide_pin_address_select,
	// Narrow port alternate sources, one bit per pin per function
	input wire logic [NARROW_W-1:0] alt1_data,
	input wire logic [NARROW_W-1:0] alt1_oe,
	input wire logic [NARROW_W-1:0] alt2_data,
	input wire logic [NARROW_W-1:0] alt2_oe,
	input wire logic [NARROW_W-1:0] alt3_data,
	input wire logic [NARROW_W-1:0] alt3_oe,
	input wire logic [NARROW_W-1:0] alt4_data,
	input wire logic [NARROW_W-1:0] alt4_oe,
	input wire logic [NARROW_W-1:0] narrow_pad_in,
	output logic [NARROW_W-1:0] narrow_pad_out,
	output logic [NARROW_W-1:0] narrow_pad_oe_n,
	output logic [NARROW_W-1:0] narrow_pad_pullup,
	output logic [NARROW_W-1:0] narrow_pin_value,
	// Serial one receive, routed in from its pin
	output logic serial_one_receive
);
	import pbc_pkg::*;

	// ==========================================
	// Registers
	logic [WIDE_W-1:0] wide_port_address_function_select_r;
	logic [WIDE_W-1:0] wide_port_drive_type_r;
	logic [WIDE_W-1:0] wide_port_pullup_enable_r;
	logic [WIDE_W-1:0] wide_port_input_enable_r;
	logic [NARROW_W-1:0] narrow_port_pin_data_r;
	logic [NARROW_W-1:0] narrow_port_output_enable_r;
	logic [NARROW_W-1:0] narrow_port_function_select_1_r;
	logic [NARROW_W-1:0] narrow_port_function_select_2_r;
	logic [NARROW_W-1:0] narrow_port_function_select_3_r;
	logic [NARROW_W-1:0] narrow_port_function_select_4_r;
	logic [NARROW_W-1:0] narrow_port_drive_type_r;
	logic [NARROW_W-1:0] narrow_port_pullup_enable_r;
	logic [NARROW_W-1:0] narrow_port_input_enable_r;

	logic wr_en;
	logic rd_en;
	logic addr_hit;
	logic [31:0] rdata_nxt;

	// Zero-wait slave: setup then one access cycle
	assign wr_en = psel & penable & pwrite & pready;
	assign rd_en = psel & ~penable;

	// ==========================================
	// Register writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wide_port_address_function_select_r <= WIDE_W'(PBC_WIDE_RST);
			wide_port_drive_type_r <= WIDE_W'(PBC_WIDE_RST);
			wide_port_pullup_enable_r <= WIDE_W'(PBC_WIDE_RST);
			wide_port_input_enable_r <= WIDE_W'(PBC_WIDE_RST);
		end
		else if (wr_en)
		begin
			unique case (paddr)
				PBC_OFF_WFS3: wide_port_address_function_select_r <= pwdata[WIDE_W-1:0];
				PBC_OFF_WOD: wide_port_drive_type_r <= pwdata[WIDE_W-1:0];
				PBC_OFF_WPUP: wide_port_pullup_enable_r <= pwdata[WIDE_W-1:0];
				PBC_OFF_WIE: wide_port_input_enable_r <= pwdata[WIDE_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// Plain port, no driver, no input, no pull-up
			narrow_port_pin_data_r <= NARROW_W'(PBC_NARROW_RST);
			narrow_port_output_enable_r <= NARROW_W'(PBC_NARROW_RST);
			narrow_port_function_select_1_r <= NARROW_W'(PBC_NARROW_RST);
			narrow_port_function_select_2_r <= NARROW_W'(PBC_NARROW_RST);
			narrow_port_function_select_3_r <= NARROW_W'(PBC_NARROW_RST);
			narrow_port_function_select_4_r <= NARROW_W'(PBC_NARROW_RST);
			narrow_port_drive_type_r <= NARROW_W'(PBC_NARROW_RST);
			narrow_port_pullup_enable_r <= NARROW_W'(PBC_NARROW_RST);
			narrow_port_input_enable_r <= NARROW_W'(PBC_NARROW_RST);
		end
		else if (wr_en)
		begin
			unique case (paddr)
				PBC_OFF_NDATA: narrow_port_pin_data_r <= pwdata[NARROW_W-1:0];
				PBC_OFF_NOE: narrow_port_output_enable_r <= pwdata[NARROW_W-1:0];
				PBC_OFF_NFS1: narrow_port_function_select_1_r <= pwdata[NARROW_W-1:0];
				PBC_OFF_NFS2: narrow_port_function_select_2_r <= pwdata[NARROW_W-1:0];
				PBC_OFF_NFS3: narrow_port_function_select_3_r <= pwdata[NARROW_W-1:0];
				PBC_OFF_NFS4: narrow_port_function_select_4_r <=
					pwdata[NARROW_W-1:0] & NARROW_W'(PBC_NFS4_MASK);
				PBC_OFF_NOD: narrow_port_drive_type_r <= pwdata[NARROW_W-1:0];
				PBC_OFF_NPUP: narrow_port_pullup_enable_r <= pwdata[NARROW_W-1:0];
				PBC_OFF_NIE: narrow_port_input_enable_r <= pwdata[NARROW_W-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// Read mux; unused upper bits read zero
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		addr_hit = 1'b1;
		unique case (paddr)
			PBC_OFF_NDATA: rdata_nxt[NARROW_W-1:0] = narrow_port_pin_data_r;
			PBC_OFF_NOE: rdata_nxt[NARROW_W-1:0] = narrow_port_output_enable_r;
			PBC_OFF_NFS1: rdata_nxt[NARROW_W-1:0] = narrow_port_function_select_1_r;
			PBC_OFF_NFS2: rdata_nxt[NARROW_W-1:0] = narrow_port_function_select_2_r;
			PBC_OFF_NFS3: rdata_nxt[NARROW_W-1:0] = narrow_port_function_select_3_r;
			PBC_OFF_NFS4: rdata_nxt[NARROW_W-1:0] = narrow_port_function_select_4_r;
			PBC_OFF_NOD: rdata_nxt[NARROW_W-1:0] = narrow_port_drive_type_r;
			PBC_OFF_NPUP: rdata_nxt[NARROW_W-1:0] = narrow_port_pullup_enable_r;
			PBC_OFF_NIE: rdata_nxt[NARROW_W-1:0] = narrow_port_input_enable_r;
			PBC_OFF_WFS3: rdata_nxt[WIDE_W-1:0] = wide_port_address_function_select_r;
			PBC_OFF_WOD: rdata_nxt[WIDE_W-1:0] = wide_port_drive_type_r;
			PBC_OFF_WPUP: rdata_nxt[WIDE_W-1:0] = wide_port_pullup_enable_r;
			PBC_OFF_WIE: rdata_nxt[WIDE_W-1:0] = wide_port_input_enable_r;
			default: addr_hit = 1'b0;
		endcase
		// Unaligned addresses are not decoded
		if (paddr[1:0] != 2'h0)
		begin
			addr_hit = 1'b0;
			rdata_nxt = 32'h0000_0000;
		end
	end

	// ==========================================
	// APB answer: registered, ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= rd_en;
			// Reserved and unmapped offsets answer with an error
			pslverr <= rd_en & ~addr_hit;
			prdata <= (rd_en & ~pwrite) ? rdata_nxt : 32'h0000_0000;
		end
	end

	// ==========================================
	// Wide port pins
	genvar gi;
	generate
		for (gi = 0; gi < WIDE_W; gi++)
		begin : g_wide
			pbc_pin_cell u_cell
			(
				.pclk(pclk),
				.presetn(presetn),
				.port_oe(wide_port_oe[gi]),
				.port_data(wide_port_data[gi]),
				.alt_sel(wide_port_address_function_select_r[gi]),
				.alt_oe(ext_addr_oe),
				.alt_data(ext_addr[gi]),
				.open_drain(wide_port_drive_type_r[gi]),
				.pullup_en(wide_port_pullup_enable_r[gi]),
				.input_en(wide_port_input_enable_r[gi]),
				.pad_in(wide_pad_in[gi]),
				.pad_out(wide_pad_out[gi]),
				.pad_oe_n(wide_pad_oe_n[gi]),
				.pad_pullup(wide_pad_pullup[gi]),
				.pin_value(wide_pin_value[gi])
			);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wide_pin_address_select <= WIDE_W'(PBC_WIDE_RST);
		else
			wide_pin_address_select <= wide_port_address_function_select_r;
	end

	// ==========================================
	// Narrow port pins
	logic [NARROW_W-1:0] n_alt_sel;
	logic [NARROW_W-1:0] n_alt_oe;
	logic [NARROW_W-1:0] n_alt_data;

	// Selects are one-hot by software contract; OR-ing keeps it cheap
	always_comb
	begin
		n_alt_sel = narrow_port_function_select_1_r | narrow_port_function_select_2_r
			| narrow_port_function_select_3_r | narrow_port_function_select_4_r;
		n_alt_oe = (narrow_port_function_select_1_r & alt1_oe)
			| (narrow_port_function_select_2_r & alt2_oe)
			| (narrow_port_function_select_3_r & alt3_oe)
			| (narrow_port_function_select_4_r & alt4_oe);
		n_alt_data = (narrow_port_function_select_1_r & alt1_data)
			| (narrow_port_function_select_2_r & alt2_data)
			| (narrow_port_function_select_3_r & alt3_data)
			| (narrow_port_function_select_4_r & alt4_data);
	end

	generate
		for (gi = 0; gi < NARROW_W; gi++)
		begin : g_narrow
			pbc_pin_cell u_cell
			(
				.pclk(pclk),
				.presetn(presetn),
				.port_oe(narrow_port_output_enable_r[gi]),
				.port_data(narrow_port_pin_data_r[gi]),
				.alt_sel(n_alt_sel[gi]),
				.alt_oe(n_alt_oe[gi]),
				.alt_data(n_alt_data[gi]),
				.open_drain(narrow_port_drive_type_r[gi]),
				.pullup_en(narrow_port_pullup_enable_r[gi]),
				.input_en(narrow_port_input_enable_r[gi]),
				.pad_in(narrow_pad_in[gi]),
				.pad_out(narrow_pad_out[gi]),
				.pad_oe_n(narrow_pad_oe_n[gi]),
				.pad_pullup(narrow_pad_pullup[gi]),
				.pin_value(narrow_pin_value[gi])
			);
		end
	endgenerate

	// Receive is fed from its pin only while selected
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			serial_one_receive <= 1'b1;
		else
			serial_one_receive <= narrow_port_function_select_1_r[PBC_SER_RX_BIT]
				? narrow_pad_in[PBC_SER_RX_BIT] : 1'b1;
	end
endmodule

// ---- bench/pbc_top_properties.sv ----
// Checker for the pin control block's bus answers and pad outputs.
// Sees only top-level ports; bound to pbc_top below.
`timescale 1ns/10ps
module pbc_top_properties
	import pbc_pkg::*;
#(
	parameter int WIDE_W = 8,
	parameter int NARROW_W = 3
)
(
	// Bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pads
	input wire logic [WIDE_W-1:0] wide_pad_in,
	input wire logic [WIDE_W-1:0] wide_pad_pullup,
	input wire logic [WIDE_W-1:0] wide_pin_value,
	input wire logic [WIDE_W-1:0] wide_pin_address_select,
	input wire logic [NARROW_W-1:0] narrow_pad_in,
	input wire logic serial_one_receive
);
	// ==========================================
	// Shadow of the registers the pads depend on
	logic [WIDE_W-1:0] wie_r;
	logic [WIDE_W-1:0] wgate;
	logic rxsel_r;
	logic rx_exp;
	logic wr_en;
	assign wr_en = psel && penable && pwrite;
	assign wgate = wide_pad_in & wie_r;
	assign rx_exp = rxsel_r ? narrow_pad_in[1] : 1'b1;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			wie_r <= '0;
		else if (wr_en && paddr == PBC_OFF_WIE)
			wie_r <= WIDE_W'(pwdata);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			rxsel_r <= 1'b0;
		else if (wr_en && paddr == PBC_OFF_NFS1)
			rxsel_r <= pwdata[1];
	// ==========================================
	// Properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_first: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_reserved: assert property (psel && !penable &&
		paddr inside {[8'h18:8'h24], [8'h30:8'h34]} |=> pslverr && prdata == 32'h0)
		else $error("reserved place answered");
	a_data_upper: assert property (psel && !penable && paddr == PBC_OFF_NDATA
		|=> prdata[31:3] == 29'h0)
		else $error("narrow data upper bits set");
	a_wide_upper: assert property (psel && !penable &&
		paddr inside {[PBC_OFF_WFS3:PBC_OFF_WIE]} |=> prdata[31:8] == 24'h0)
		else $error("wide register upper bits set");
	a_pullup_copy: assert property (wr_en && paddr == PBC_OFF_WPUP
		|-> ##2 wide_pad_pullup == WIDE_W'($past(pwdata, 2)))
		else $error("pull-up pads not following register");
	a_addr_copy: assert property (wr_en && paddr == PBC_OFF_WFS3
		|-> ##2 wide_pin_address_select == WIDE_W'($past(pwdata, 2)))
		else $error("address select not following register");
	a_input_gate: assert property (wide_pin_value == $past(wgate))
		else $error("pin value not gated by input enable");
	a_serial_rx: assert property (serial_one_receive == $past(rx_exp))
		else $error("serial receive routing wrong");
endmodule

bind pbc_top pbc_top_properties #(.WIDE_W(WIDE_W), .NARROW_W(NARROW_W)) u_props
(
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .wide_pad_in, .wide_pad_pullup, .wide_pin_value, .wide_pin_address_select,
	.narrow_pad_in, .serial_one_receive
);

// ---- bench/pbc_pad_model.sv ----
// Pad model: resolves each pin from the block's driver and pull-up.
// Assumes the bench gives the level of a weak outside source.
`timescale 1ns/10ps
module pbc_pad_model
#(
	parameter int W = 8
)
(
	// From the block
	input wire logic [W-1:0] pad_out,
	input wire logic [W-1:0] pad_oe_n,
	input wire logic [W-1:0] pad_pullup,
	// Outside world
	input wire logic [W-1:0] ext_lvl,
	output logic [W-1:0] pad_in
);
	// Undriven pin: pull-up beats the weak outside source
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & (pad_pullup | ext_lvl));
endmodule

// ---- bench/port_b_c_pin_control_bench.sv ----
// Self-checking bench for the pin control block over APB.
// Assumes zero-wait APB and pads lagging registers by one edge.
`timescale 1ns/10ps
module port_b_c_pin_control_bench;
	import pbc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, ext_addr_oe;
	logic serial_one_receive;
	logic [7:0] paddr, wide_port_oe, wide_port_data, ext_addr, w_lvl, wide_pad_in;
	logic [7:0] wide_pad_out, wide_pad_oe_n, wide_pad_pullup, wide_pin_value;
	logic [7:0] wide_pin_address_select;
	logic [2:0] n_lvl, narrow_pad_in, narrow_pad_out, narrow_pad_oe_n, narrow_pad_pullup;
	logic [2:0] narrow_pin_value;
	logic [3:0][2:0] ad, ao;
	logic [31:0] pwdata, prdata, rdat;
	int mismatches, n_checks;
	logic [7:0] offs [13] = '{PBC_OFF_NDATA, PBC_OFF_NOE, PBC_OFF_NFS1, PBC_OFF_NFS2,
		PBC_OFF_NFS3, PBC_OFF_NFS4, PBC_OFF_NOD, PBC_OFF_NPUP, PBC_OFF_NIE,
		PBC_OFF_WFS3, PBC_OFF_WOD, PBC_OFF_WPUP, PBC_OFF_WIE};
	// Select writes keep one function per pin
	logic [31:0] wv [13] = '{'1, '1, 32'hfffffff9, 32'hfffffffa, 32'hfffffffc,
		32'hfffffffb, '1, '1, '1, '1, '1, '1, '1};
	logic [31:0] ev [13] = '{7, 7, 1, 2, 4, 0, 7, 7, 7, 'hff, 'hff, 'hff, 'hff};
	logic [7:0] rsv [6] = '{8'h18, 8'h24, 8'h30, 8'h34, 8'h80, 8'h02};
	logic [7:0] fs [4] = '{PBC_OFF_NFS1, PBC_OFF_NFS2, PBC_OFF_NFS3, PBC_OFF_NFS4};

	pbc_top i_pbc_top
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .wide_port_oe, .wide_port_data, .ext_addr, .ext_addr_oe, .wide_pad_in,
		.wide_pad_out, .wide_pad_oe_n, .wide_pad_pullup, .wide_pin_value,
		.wide_pin_address_select, .alt1_data(ad[0]), .alt1_oe(ao[0]),
		.alt2_data(ad[1]), .alt2_oe(ao[1]), .alt3_data(ad[2]), .alt3_oe(ao[2]),
		.alt4_data(ad[3]), .alt4_oe(ao[3]), .narrow_pad_in, .narrow_pad_out,
		.narrow_pad_oe_n, .narrow_pad_pullup, .narrow_pin_value, .serial_one_receive
	);
	pbc_pad_model #(.W(8)) i_pbc_pad_model_w (.pad_out(wide_pad_out),
		.pad_oe_n(wide_pad_oe_n), .pad_pullup(wide_pad_pullup), .ext_lvl(w_lvl),
		.pad_in(wide_pad_in));
	pbc_pad_model #(.W(3)) i_pbc_pad_model_n (.pad_out(narrow_pad_out),
		.pad_oe_n(narrow_pad_oe_n), .pad_pullup(narrow_pad_pullup), .ext_lvl(n_lvl),
		.pad_in(narrow_pad_in));

	// ==========================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n >= 16)
		begin
			mismatches++;
			$display("ERROR pready expected 1 seen %b", pready);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(what, exp, rdat);
	endtask
	// Register to pad output to registered pin value
	task automatic settle();
		repeat (4) @(posedge pclk);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		foreach (offs[i]) rd("reset value", offs[i], 32'h0);
		chk("narrow oe_n", 32'h7, 32'(narrow_pad_oe_n));
		chk("narrow pull-up", 32'h0, 32'(narrow_pad_pullup));
		$display("test reset done");
	endtask
	task automatic t_regs();
		foreach (offs[i]) wr(offs[i], wv[i]);
		foreach (offs[i]) rd("register", offs[i], ev[i]);
		foreach (rsv[i])
		begin
			wr(rsv[i], '1);
			chk("write error", 32'h1, 32'(rerr));
			rd("refused place", rsv[i], 32'h0);
		end
		foreach (offs[i]) wr(offs[i], 32'h0);
		$display("test registers done");
	endtask
	task automatic t_narrow();
		wr(PBC_OFF_NDATA, 32'h5);
		wr(PBC_OFF_NOE, 32'h3);
		settle();
		chk("narrow oe_n", 32'h4, 32'(narrow_pad_oe_n));
		chk("narrow out", 32'h1, 32'(narrow_pad_out & 3'h3));
		wr(PBC_OFF_NOE, 32'h4);
		settle();
		chk("narrow oe_n", 32'h3, 32'(narrow_pad_oe_n));
		chk("narrow out", 32'h4, 32'(narrow_pad_out & 3'h4));
		$display("test narrow drive done");
	endtask
	task automatic t_wide();
		wide_port_oe <= 8'hff;
		wide_port_data <= 8'h3c;
		wr(PBC_OFF_WOD, 32'hf0);
		settle();
		chk("open drain oe_n", 32'h30, 32'(wide_pad_oe_n));
		chk("open drain out", 32'h0c, 32'(wide_pad_out));
		wr(PBC_OFF_WOD, 32'h0);
		ext_addr <= 8'hff;
		ext_addr_oe <= 1'b1;
		wr(PBC_OFF_WFS3, 32'ha5);
		settle();
		chk("address out", 32'hbd, 32'(wide_pad_out));
		chk("address oe_n", 32'h0, 32'(wide_pad_oe_n));
		ext_addr_oe <= 1'b0;
		settle();
		chk("address float", 32'ha5, 32'(wide_pad_oe_n));
		$display("test wide drive done");
	endtask
	task automatic t_input();
		wide_port_oe <= 8'h00;
		w_lvl <= 8'h50;
		wr(PBC_OFF_WFS3, 32'h0);
		wr(PBC_OFF_WPUP, 32'h0f);
		wr(PBC_OFF_WIE, 32'h33);
		settle();
		chk("pull-up", 32'h0f, 32'(wide_pad_pullup));
		chk("pin value", 32'h13, 32'(wide_pin_value));
		$display("test input done");
	endtask
	task automatic t_alt();
		wr(PBC_OFF_NDATA, 32'h0);
		wr(PBC_OFF_NOE, 32'h0);
		for (int k = 0; k < 4; k++)
		begin
			// One source per pass, set in a single assignment
			ad <= 12'h004 << (3 * k);
			ao <= 12'h004 << (3 * k);
			wr(fs[k], 32'h4);
			settle();
			chk("alternate out", 32'h4, 32'(narrow_pad_out & ~narrow_pad_oe_n));
			wr(fs[k], 32'h0);
		end
		n_lvl <= 3'h0;
		wr(PBC_OFF_NFS1, 32'h2);
		settle();
		chk("serial receive", 32'h0, 32'(serial_one_receive));
		wr(PBC_OFF_NFS1, 32'h0);
		settle();
		chk("serial idle", 32'h1, 32'(serial_one_receive));
		wr(PBC_OFF_NPUP, 32'h5);
		wr(PBC_OFF_NIE, 32'h3);
		settle();
		chk("narrow pull-up", 32'h5, 32'(narrow_pad_pullup));
		chk("narrow pin value", 32'h1, 32'(narrow_pin_value));
		wr(PBC_OFF_NDATA, 32'h3);
		wr(PBC_OFF_NOE, 32'h3);
		wr(PBC_OFF_NOD, 32'h1);
		settle();
		chk("narrow open drain", 32'h5, 32'(narrow_pad_oe_n));
		$display("test alternate done");
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial
	begin
		#1000000;
		mismatches++;
		$display("ERROR watchdog expected done seen timeout");
		conclude();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, ext_addr_oe, paddr, pwdata} = '0;
		{wide_port_oe, wide_port_data, ext_addr, w_lvl, n_lvl, ad, ao} = '0;
		mismatches = 0;
		n_checks = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_narrow();
		t_wide();
		t_input();
		t_alt();
		conclude();
	end
endmodule
